// ---- vic_top.sv ----
// Purpose: Vectored interrupt controller toward the CPU core
// Assumes: Sources are synchronous to SYS_CLK; CPU handshakes on IRQ
// Notes:   Configuration arrives as plain per-vector write ports
`timescale 1ns/1ps
`default_nettype none
module vic_top (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic        CLK_EN,
   // Request lines: fixed-function, DMA terminal and routed
   input  wire logic        LOW_VOLTAGE_DETECT,
   input  wire logic        ECC_ERR,
   input  wire logic        SLEEP_INT,
   input  wire logic [15:0] PORT_INTERRUPT_UNIT,
   input  wire logic        CMP_INT,
   input  wire logic        SC_INT,
   input  wire logic        I2C_INT,
   input  wire logic        CAN_INT,
   input  wire logic [3:0]  TIMER_INT,
   input  wire logic [4:0]  USB_INT,
   input  wire logic        DECIM_INT,
   input  wire logic        BUS_ERR_INT,
   input  wire logic        EEPROM_FAULT,
   input  wire logic [15:0] DMA_TERMINAL_OUT_LOW,
   input  wire logic [15:0] DMA_TERMINAL_OUT_HIGH,
   input  wire logic [31:0] ROUTED_INT,
   // Per-vector configuration writes
   input  wire logic        CFG_WE,
   input  wire logic [4:0]  CFG_VEC,
   input  wire logic        CFG_ENABLE,
   input  wire logic [2:0]  CFG_PRIO,
   input  wire logic [1:0]  CFG_SRC,
   input  wire logic [15:0] CFG_ADDR,
   input  wire logic [31:0] SW_SET_PEND,
   input  wire logic [31:0] SW_CLR_PEND,
   // CPU side
   input  wire logic        IRQ_ACK,
   input  wire logic        RETURN_FROM_INTERRUPT_INSTR,
   output logic             IRQ,
   output logic [4:0]       IRQ_VEC,
   output logic [15:0]      IRQ_ADDR,
   output logic [31:0]      PENDING,
   output logic [7:0]       ACTIVE_LEVELS
);
   logic [31:0]                 enable_r;
   logic [vic_pkg::PRIO_W-1:0]  prio_r   [vic_pkg::NUM_VEC];
   logic [1:0]                  src_r    [vic_pkg::NUM_VEC];
   logic [vic_pkg::ADDR_W-1:0]  addr_r   [vic_pkg::NUM_VEC];
   logic [31:0]                 pend_r;
   logic [31:0]                 pend_nxt;
   logic [7:0]                  act_r;
   logic [31:0]                 fixed_vec;
   logic [31:0]                 dma_vec;
   logic [31:0]                 req_vec;
   logic                        win_valid;
   logic [4:0]                  win_vec;
   logic [2:0]                  win_prio;
   logic                        preempt;
   logic                        irq_r;
   logic [4:0]                  irq_vec_r;
   logic [15:0]                 irq_addr_r;
   vic_pkg::take_st_t           st_r;
   logic                        take;

   // Lowest set bit index of an 8-bit level mask
   function automatic logic [3:0] low_level(input logic [7:0] m);
      logic [3:0] r;
      r = 4'h8;
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // Fixed-function wiring
   always_comb begin
      fixed_vec = '0;
      fixed_vec[vic_pkg::V_LVD] = LOW_VOLTAGE_DETECT;
      fixed_vec[vic_pkg::V_ECC] = ECC_ERR;
      fixed_vec[vic_pkg::V_SLEEP] = SLEEP_INT;
      for (int i = 0; i < vic_pkg::N_PORTLOW; i++) begin
         fixed_vec[vic_pkg::V_PORT0+i] = PORT_INTERRUPT_UNIT[i];
      end
      fixed_vec[vic_pkg::V_PORT12] = PORT_INTERRUPT_UNIT[12];
      fixed_vec[vic_pkg::V_PORT15] = PORT_INTERRUPT_UNIT[15];
      fixed_vec[vic_pkg::V_CMP] = CMP_INT;
      fixed_vec[vic_pkg::V_SC] = SC_INT;
      fixed_vec[vic_pkg::V_I2C] = I2C_INT;
      fixed_vec[vic_pkg::V_CAN] = CAN_INT;
      for (int i = 0; i < vic_pkg::N_TMR; i++) begin
         fixed_vec[vic_pkg::V_TMR0+i] = TIMER_INT[i];
      end
      for (int i = 0; i < vic_pkg::N_USB; i++) begin
         fixed_vec[vic_pkg::V_USB0+i] = USB_INT[i];
      end
      fixed_vec[vic_pkg::V_DEC] = DECIM_INT;
      fixed_vec[vic_pkg::V_BUSERR] = BUS_ERR_INT;
      fixed_vec[vic_pkg::V_EEFAULT] = EEPROM_FAULT;
      fixed_vec = fixed_vec & ~vic_pkg::RESERVED_MASK;
   end

   assign dma_vec = {DMA_TERMINAL_OUT_HIGH, DMA_TERMINAL_OUT_LOW};

   // Source selection per vector
   always_comb begin
      for (int v = 0; v < vic_pkg::NUM_VEC; v++) begin
         case (vic_pkg::src_sel_t'(src_r[v]))
            vic_pkg::SRC_FIXED: req_vec[v] = fixed_vec[v];
            vic_pkg::SRC_DMA:   req_vec[v] = dma_vec[v];
            vic_pkg::SRC_ROUTE: req_vec[v] = ROUTED_INT[v];
            default:            req_vec[v] = 1'b0;
         endcase
      end
   end

   // Configuration store
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         enable_r <= '0;
         for (int v = 0; v < vic_pkg::NUM_VEC; v++) begin
            prio_r[v] <= vic_pkg::PRIO_RST;
            src_r[v]  <= vic_pkg::SRC_FIXED;
            addr_r[v] <= vic_pkg::ADDR_RST;
         end
      end else if (CLK_EN && CFG_WE) begin
         enable_r[CFG_VEC] <= CFG_ENABLE;
         prio_r[CFG_VEC]   <= CFG_PRIO;
         src_r[CFG_VEC]    <= CFG_SRC;
         addr_r[CFG_VEC]   <= CFG_ADDR;
      end
   end

   // Arbitration: best priority, lowest number on ties
   always_comb begin
      win_valid = 1'b0;
      win_vec   = '0;
      win_prio  = '1;
      for (int v = 0; v < vic_pkg::NUM_VEC; v++) begin
         if (pend_r[v] && enable_r[v] &&
             (!win_valid || prio_r[v] < win_prio)) begin
            win_valid = 1'b1;
            win_vec   = 5'(v);
            win_prio  = prio_r[v];
         end
      end
   end

   // Preempts only a strictly better level than any active one
   assign preempt = win_valid &&
                    ({1'b0, win_prio} < low_level(act_r));
   assign take = irq_r && IRQ_ACK;

   // Pending state
   always_comb begin
      pend_nxt = pend_r & ~SW_CLR_PEND;
      if (take) begin
         pend_nxt[irq_vec_r] = 1'b0;
      end
      pend_nxt = pend_nxt | SW_SET_PEND | (req_vec & enable_r);
   end

   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         pend_r <= '0;
      end else if (CLK_EN) begin
         pend_r <= pend_nxt;
      end
   end

   // Request handshake toward the CPU
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         st_r       <= vic_pkg::ST_IDLE;
         irq_r      <= 1'b0;
         irq_vec_r  <= '0;
         irq_addr_r <= '0;
      end else if (CLK_EN) begin
         case (st_r)
            vic_pkg::ST_IDLE: begin
               if (preempt && !RETURN_FROM_INTERRUPT_INSTR) begin
                  st_r       <= vic_pkg::ST_REQ;
                  irq_r      <= 1'b1;
                  irq_vec_r  <= win_vec;
                  irq_addr_r <= addr_r[win_vec];
               end
            end
            vic_pkg::ST_REQ: begin
               if (take || !pend_r[irq_vec_r] || !enable_r[irq_vec_r]) begin
                  st_r  <= vic_pkg::ST_IDLE;
                  irq_r <= 1'b0;
               end
            end
            default: begin
               st_r  <= vic_pkg::ST_IDLE;
               irq_r <= 1'b0;
            end
         endcase
      end
   end

   // Active priority level stack
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         act_r <= '0;
      end else if (CLK_EN) begin
         if (take) begin
            act_r[prio_r[irq_vec_r]] <= 1'b1;
         end else if (RETURN_FROM_INTERRUPT_INSTR && act_r != '0) begin
            act_r[3'(low_level(act_r))] <= 1'b0;
         end
      end
   end

   assign IRQ           = irq_r;
   assign IRQ_VEC       = irq_vec_r;
   assign IRQ_ADDR      = irq_addr_r;
   assign PENDING       = pend_r;
   assign ACTIVE_LEVELS = act_r;

   chk_take_clears_pend: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && take && !SW_SET_PEND[irq_vec_r] &&
       !(req_vec[irq_vec_r] && enable_r[irq_vec_r]))
      |=> !pend_r[$past(irq_vec_r)])
      else $error("accepted vector still pending");

   chk_swset_pend: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && SW_SET_PEND != '0) |=> ((pend_r & $past(SW_SET_PEND))
                                          == $past(SW_SET_PEND)))
      else $error("software set lost");

   chk_swclr_pend: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && SW_CLR_PEND != '0) |=>
      ((pend_r & $past(SW_CLR_PEND & ~SW_SET_PEND & ~(req_vec & enable_r)))
       == '0))
      else $error("software clear ignored");

   chk_irq_enabled: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      $rose(irq_r) |-> $past(enable_r[win_vec] && pend_r[win_vec]))
      else $error("request from disabled vector");

   chk_addr_match: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      $rose(irq_r) |-> irq_addr_r == $past(addr_r[win_vec]))
      else $error("vector address mismatch");

   chk_level_set: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && take) |=> act_r[$past(prio_r[irq_vec_r])])
      else $error("active level not opened");

   chk_return_from_interrupt_instr_close: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && !take && RETURN_FROM_INTERRUPT_INSTR && act_r != '0)
      |=> $countones(act_r) == $countones($past(act_r)) - 1)
      else $error("level not closed on return");

   chk_preempt_only: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      $rose(irq_r) |-> {1'b0, $past(win_prio)} < $past(low_level(act_r)))
      else $error("request without preemption");

   chk_reserved_fixed: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (fixed_vec & vic_pkg::RESERVED_MASK) == '0)
      else $error("reserved vector driven");

   sequence s_accept;
      CLK_EN && take;
   endsequence

   sequence s_released;
      !irq_r && act_r[$past(prio_r[irq_vec_r])];
   endsequence

   chk_accept_release: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      s_accept |=> s_released)
      else $error("request not released on accept");

   chk_irq_holds: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (CLK_EN && irq_r && !take && pend_r[irq_vec_r] &&
       enable_r[irq_vec_r]) |=> (irq_r && $stable(irq_vec_r) &&
                                 $stable(irq_addr_r)))
      else $error("request dropped before accept");

   chk_ret_blocks_irq: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      (RETURN_FROM_INTERRUPT_INSTR && !irq_r) |=> !irq_r)
      else $error("request raised during return");

   chk_freeze_state: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      !CLK_EN |=> ($stable(pend_r) && $stable(act_r) && $stable(irq_r)))
      else $error("state moved while clock enable low");

   // Lower-numbered rival that should have won
   logic tie_lower;
   always_comb begin
      tie_lower = 1'b0;
      for (int v = 0; v < vic_pkg::NUM_VEC; v++) begin
         if (5'(v) < win_vec && pend_r[v] && enable_r[v] &&
             prio_r[v] <= win_prio) begin
            tie_lower = 1'b1;
         end
      end
   end

   chk_tie_lowest: assert property (
      @(posedge SYS_CLK) disable iff (RESET)
      $rose(irq_r) |-> !$past(tie_lower))
      else $error("higher-numbered vector won a tie");
endmodule // vic_top
`default_nettype wire

// ---- vic_pkg.sv ----
// Purpose: Constants and types for the vectored interrupt controller
// Assumes: 32 vectors, eight priority levels, 16-bit code space
// Notes:   Functional notes follow
//
// Functional notes
// - Thirty-two vectors, 0 to 31, each with its own request path.
// - Every vector has its own enable bit.
// - Every vector has a writable three-bit priority, changeable any time.
// - Nesting up to eight levels; higher priority preempts lower running level.
// - Every vector holds a programmable code-space target address.
// - Software write forces a vector pending without hardware request.
// - Software write clears a vector's pending state before service.
// - On take, CPU finishes instruction, pushes PC, fetches vector address.
// - Return-from-interrupt pops PC; controller closes the active level.
// - Equal priority ties go to the lowest vector number.
// - Per-vector selector: fixed line, DMA line or routed line.
// - DMA sources: vectors 0-15 low terminal bus, 16-31 high bus.
// - Routed source of vector n is bit n of 32-bit routed bus.
// - Any source can reach any vector through the routed connection.
// - Fixed lines hardwired per vector table; vectors 2, 26-28 reserved.
// - Port units 0-6 feed vectors 4-10; units 12, 15 feed 11, 12.
package vic_pkg;
   localparam int NUM_VEC     = 32;
   localparam int VEC_W       = 5;
   localparam int PRIO_W      = 3;
   localparam int NUM_LEVELS  = 8;
   localparam int ADDR_W      = 16;
   localparam int DMA_HALF    = 16;
   localparam int PORT_UNITS  = 16;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic [PRIO_W-1:0] PRIO_RST = 3'h7;
   localparam logic [NUM_VEC-1:0] RESERVED_MASK = 32'h1c000004;
   // Fixed-function vector positions
   localparam int V_LVD     = 0;
   localparam int V_ECC     = 1;
   localparam int V_SLEEP   = 3;
   localparam int V_PORT0   = 4;
   localparam int V_PORT12  = 11;
   localparam int V_PORT15  = 12;
   localparam int V_CMP     = 13;
   localparam int V_SC      = 14;
   localparam int V_I2C     = 15;
   localparam int V_CAN     = 16;
   localparam int V_TMR0    = 17;
   localparam int V_USB0    = 21;
   localparam int V_DEC     = 29;
   localparam int V_BUSERR  = 30;
   localparam int V_EEFAULT = 31;
   localparam int N_PORTLOW = 7;
   localparam int N_TMR     = 4;
   localparam int N_USB     = 5;
   typedef enum logic [1:0] {
      SRC_FIXED = 2'h0,
      SRC_DMA   = 2'h1,
      SRC_ROUTE = 2'h2,
      SRC_NONE  = 2'h3
   } src_sel_t;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_REQ    = 2'h1
   } take_st_t;
endpackage

// ---- cpu_model.sv ----
// Purpose: CPU core stand-in taking vectored interrupts
// Assumes: One clock, handshake on IRQ and IRQ_ACK
// Notes:   Ack delay set by the bench, zero for prompt
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        irq,
   input  wire logic [4:0]  vec,
   input  wire logic [15:0] addr,
   input  wire logic [3:0]  dly,
   input  wire logic        ret_req,
   output logic             ack,
   output logic             ret,
   output logic [4:0]       got_vec,
   output logic [15:0]      got_addr,
   output int               n_taken
);
   logic [3:0] cnt_r;
   // Take after dly cycles, latch vector and address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack      <= 1'b0;
         cnt_r    <= 4'h0;
         got_vec  <= 5'h00;
         got_addr <= 16'h0000;
         n_taken  <= 0;
      end else if (irq && !ack && cnt_r >= dly) begin
         ack      <= 1'b1;
         cnt_r    <= 4'h0;
         got_vec  <= vec;
         got_addr <= addr;
         n_taken  <= n_taken + 1;
      end else begin
         ack   <= 1'b0;
         cnt_r <= (irq && !ack) ? cnt_r + 4'h1 : 4'h0;
      end
   end
   // Return instruction on request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ret <= 1'b0;
      else     ret <= ret_req;
   end
endmodule // cpu_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the interrupt controller
// Assumes: vic_pkg, vic_top and cpu_model compiled first
// Notes:   Random addresses, priorities, ack delays; seed 516
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst = 1'b1, ret_req = 1'b0;
   logic [31:0] fxv = 32'h0, dmav = 32'h0, rt = 32'h0;
   logic [31:0] sw_set = 32'h0, sw_clr = 32'h0, pending;
   logic        cfg_we = 1'b0, cfg_en = 1'b0, irq, ack, ret, ce = 1'b1;
   logic [4:0]  cfg_vec = 5'h00, irq_vec, got_vec;
   logic [2:0]  cfg_prio = 3'h0;
   logic [1:0]  cfg_src = 2'h0;
   logic [15:0] cfg_addr = 16'h0, irq_addr, got_addr;
   logic [15:0] exp_a [32];
   logic [7:0]  active;
   logic [3:0]  dly = 4'h0;
   int          n_taken, fails = 0, n_checks = 0;
   always #5 clk = ~clk;
   vic_top i_vic_top (.SYS_CLK(clk), .RESET(rst), .CLK_EN(ce),
      .LOW_VOLTAGE_DETECT(fxv[0]), .ECC_ERR(fxv[1]), .SLEEP_INT(fxv[3]),
      .PORT_INTERRUPT_UNIT({fxv[12], 2'h0, fxv[11], 5'h00, fxv[10:4]}),
      .CMP_INT(fxv[13]), .SC_INT(fxv[14]), .I2C_INT(fxv[15]),
      .CAN_INT(fxv[16]), .TIMER_INT(fxv[20:17]), .USB_INT(fxv[25:21]),
      .DECIM_INT(fxv[29]), .BUS_ERR_INT(fxv[30]), .EEPROM_FAULT(fxv[31]),
      .DMA_TERMINAL_OUT_LOW(dmav[15:0]), .DMA_TERMINAL_OUT_HIGH(dmav[31:16]),
      .ROUTED_INT(rt), .CFG_WE(cfg_we), .CFG_VEC(cfg_vec),
      .CFG_ENABLE(cfg_en), .CFG_PRIO(cfg_prio), .CFG_SRC(cfg_src),
      .CFG_ADDR(cfg_addr), .SW_SET_PEND(sw_set), .SW_CLR_PEND(sw_clr),
      .IRQ_ACK(ack), .RETURN_FROM_INTERRUPT_INSTR(ret), .IRQ(irq),
      .IRQ_VEC(irq_vec), .IRQ_ADDR(irq_addr), .PENDING(pending),
      .ACTIVE_LEVELS(active));
   cpu_model i_cpu_model (.clk(clk), .rst(rst), .irq(irq), .vec(irq_vec),
      .addr(irq_addr), .dly(dly), .ret_req(ret_req), .ack(ack), .ret(ret),
      .got_vec(got_vec), .got_addr(got_addr), .n_taken(n_taken));
   task tick;
      @(posedge clk);
      #1;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Active level mask expected for one open level
   function automatic logic [31:0] exp_level(input int p);
      return 32'h1 << p;
   endfunction
   task results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task cfg(input int v, input logic en, input logic [2:0] p,
            input logic [1:0] s);
      exp_a[v] = 16'($urandom);
      cfg_vec = 5'(v);
      cfg_en = en;
      cfg_prio = p;
      cfg_src = s;
      cfg_addr = exp_a[v];
      cfg_we = 1'b1;
      tick;
      cfg_we = 1'b0;
      tick;
   endtask
   // One-cycle request on the chosen source
   task pulse(input int s, input int v);
      if (s == 0) fxv[v] = 1'b1;
      else if (s == 1) dmav[v] = 1'b1;
      else rt[v] = 1'b1;
      tick;
      fxv = 32'h0;
      dmav = 32'h0;
      rt = 32'h0;
   endtask
   task swset(input logic [31:0] m);
      sw_set = m;
      tick;
      sw_set = 32'h0;
   endtask
   task take(input int v);
      int n0;
      n0 = n_taken;
      repeat (40) if (n_taken == n0) tick;
      chk(n_taken, n0 + 1);
      chk(got_vec, v);
      chk(got_addr, exp_a[v]);
      tick;
      chk(pending[v], 1'b0);
   endtask
   task rtn;
      ret_req = 1'b1;
      tick;
      ret_req = 1'b0;
      repeat (2) tick;
   endtask
   initial begin
      int p;
      p = $urandom(516);
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      chk(pending, 32'h0);
      chk(active, 8'h00);
      for (int s = 0; s < 3; s++) begin
         for (int v = 0; v < 32; v++) begin
            if (s == 0 && vic_pkg::RESERVED_MASK[v]) continue;
            p = $urandom_range(0, 7);
            dly = 4'($urandom_range(0, 6));
            cfg(v, 1'b0, 3'(p), 2'(s));
            pulse(s, v);
            tick;
            chk(pending[v], 1'b0);
            cfg(v, 1'b1, 3'(p), 2'(s));
            pulse(s, v);
            take(v);
            chk(active, exp_level(p));
            rtn;
            chk(active, 8'h00);
         end
      end
      dly = 4'h0;
      cfg(5, 1'b1, 3'h2, 2'h3);
      cfg(9, 1'b1, 3'h2, 2'h3);
      cfg(20, 1'b1, 3'h1, 2'h3);
      cfg(7, 1'b1, 3'h4, 2'h3);
      swset(32'h0000_0220);
      take(5);
      repeat (8) tick;
      chk(pending[9], 1'b1);
      swset(32'h0010_0000);
      take(20);
      chk(active, exp_level(1) | exp_level(2));
      swset(32'h0000_0080);
      sw_clr = 32'h0000_0080;
      tick;
      sw_clr = 32'h0;
      chk(pending[7], 1'b0);
      rtn;
      rtn;
      take(9);
      rtn;
      repeat (8) tick;
      chk(irq, 1'b0);
      chk(active, 8'h00);
      ce = 1'b0;
      swset(32'h0000_0080);
      chk(pending[7], 1'b0);
      ce = 1'b1;
      swset(32'h0000_0080);
      chk(pending[7], 1'b1);
      take(7);
      rtn;
      chk(active, 8'h00);
      results;
   end
   initial begin
      #400000;
      fails++;
      results;
   end
endmodule // tb_top
`default_nettype wire
